// ---- design/wwd_top.sv ----
// windowed watchdog timer with AXI4-Lite register slave
`timescale 1ns/100ps
module wwd_top #(
	parameter logic [18:0] BUS_TO_SHORT = wwd_pkg::BUS_TO_SHORT,
	parameter logic [18:0] BUS_TO_MID = wwd_pkg::BUS_TO_MID,
	parameter logic [18:0] BUS_TO_LONG = wwd_pkg::BUS_TO_LONG,
	parameter logic [18:0] BUS_WIN_SHORT = wwd_pkg::BUS_WIN_SHORT,
	parameter logic [18:0] BUS_WIN_MID = wwd_pkg::BUS_WIN_MID,
	parameter logic [18:0] BUS_WIN_LONG = wwd_pkg::BUS_WIN_LONG,
	parameter int LPO_DIV = wwd_pkg::LPO_DIV
)(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic por_n,
	input wire logic stop_mode,
	input wire logic debug_mode,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic sys_reset_req
);
	// ==========================================================
	// elaboration checks
	initial
	begin
		if (LPO_DIV < 2 || LPO_DIV > 32768)
			$error("LPO_DIV out of range");
		if (BUS_WIN_SHORT >= BUS_TO_SHORT || BUS_WIN_MID >= BUS_TO_MID)
			$error("window must open before timeout");
		if (BUS_WIN_LONG >= BUS_TO_LONG || BUS_TO_SHORT == 19'h0_0000)
			$error("bad bus timeout settings");
	end

	localparam logic [14:0] LPO_LAST = 15'(LPO_DIV - 1);

	// ==========================================================
	// state
	wwd_pkg::wwd_cfg_t cfg_ff, nxt_cfg_ff;
	wwd_pkg::wwd_svc_t svc_ff, nxt_svc_ff;
	logic opt1_lock_ff, nxt_opt1_lock_ff;
	logic opt2_lock_ff, nxt_opt2_lock_ff;
	logic [18:0] cnt_ff, nxt_cnt_ff;
	logic [14:0] lpo_ff, nxt_lpo_ff;
	logic aw_ok_ff, nxt_aw_ok_ff;
	logic w_ok_ff, nxt_w_ok_ff;
	logic [31:0] awaddr_ff, nxt_awaddr_ff;
	logic [31:0] wdata_ff, nxt_wdata_ff;
	logic bvalid_ff, nxt_bvalid_ff;
	logic [1:0] bresp_ff, nxt_bresp_ff;
	logic rvalid_ff, nxt_rvalid_ff;
	logic [31:0] rdata_ff, nxt_rdata_ff;
	logic [1:0] rresp_ff, nxt_rresp_ff;
	logic hold_ff, nxt_hold_ff;
	logic cause_ff, nxt_cause_ff;
	logic in_wd_rst_ff, nxt_in_wd_rst_ff;

	// ==========================================================
	// decode
	logic wr_do, rs_wr, is_first, is_second, enabled, windowed, halt, tick;
	logic early, fire_bad, fire_early, fire_to, svc_done, fire;
	logic [18:0] limit, win_open;

	always_comb
	begin
		wr_do = aw_ok_ff & w_ok_ff;
		rs_wr = wr_do & (awaddr_ff == wwd_pkg::ADDR_RSTAT);
		is_first = (wdata_ff == wwd_pkg::SVC_FIRST);
		is_second = (wdata_ff == wwd_pkg::SVC_SECOND);
		enabled = (cfg_ff.tsel != wwd_pkg::TSEL_OFF);
		windowed = cfg_ff.clk_sel & cfg_ff.win_en;
		halt = stop_mode | debug_mode;
		tick = cfg_ff.clk_sel | (lpo_ff == LPO_LAST);
		case (cfg_ff.tsel)
			wwd_pkg::TSEL_SHORT:
			begin
				limit = cfg_ff.clk_sel ? BUS_TO_SHORT : wwd_pkg::LPO_TO_SHORT;
				win_open = BUS_WIN_SHORT;
			end
			wwd_pkg::TSEL_MID:
			begin
				limit = cfg_ff.clk_sel ? BUS_TO_MID : wwd_pkg::LPO_TO_MID;
				win_open = BUS_WIN_MID;
			end
			default:
			begin
				limit = cfg_ff.clk_sel ? BUS_TO_LONG : wwd_pkg::LPO_TO_LONG;
				win_open = BUS_WIN_LONG;
			end
		endcase
		early = windowed & (cnt_ff < win_open);
		// illegal values reset even while the timer is off
		fire_bad = rs_wr & ~is_first & ~is_second;
		fire_early = rs_wr & (is_first | is_second) & enabled & early;
		svc_done = rs_wr & is_second & (svc_ff == wwd_pkg::SVC_ARMED) & ~early;
		fire_to = enabled & tick & ~halt & ~svc_done & (cnt_ff == limit - 19'h0_0001);
		fire = rst_n & (fire_bad | fire_early | fire_to);
	end

	// ==========================================================
	// next values
	always_comb
	begin
		nxt_cfg_ff = cfg_ff;
		nxt_opt1_lock_ff = opt1_lock_ff;
		nxt_opt2_lock_ff = opt2_lock_ff;
		nxt_svc_ff = svc_ff;
		nxt_cnt_ff = cnt_ff;
		nxt_lpo_ff = (lpo_ff == LPO_LAST) ? 15'h0000 : lpo_ff + 15'h0001;
		nxt_aw_ok_ff = aw_ok_ff;
		nxt_w_ok_ff = w_ok_ff;
		nxt_awaddr_ff = awaddr_ff;
		nxt_wdata_ff = wdata_ff;
		nxt_bvalid_ff = bvalid_ff;
		nxt_bresp_ff = bresp_ff;
		nxt_rvalid_ff = rvalid_ff;
		nxt_rdata_ff = rdata_ff;
		nxt_rresp_ff = rresp_ff;
		// address and data are taken in either order, then committed together
		if (s_axi_awvalid & s_axi_awready)
		begin
			nxt_aw_ok_ff = 1'b1;
			nxt_awaddr_ff = s_axi_awaddr;
		end
		if (s_axi_wvalid & s_axi_wready)
		begin
			nxt_w_ok_ff = 1'b1;
			nxt_wdata_ff = s_axi_wdata;
		end
		if (s_axi_bvalid & s_axi_bready)
			nxt_bvalid_ff = 1'b0;
		if (wr_do)
		begin
			nxt_aw_ok_ff = 1'b0;
			nxt_w_ok_ff = 1'b0;
			nxt_bvalid_ff = 1'b1;
			nxt_bresp_ff = wwd_pkg::RESP_OKAY;
			case (awaddr_ff)
				wwd_pkg::ADDR_RSTAT:
				begin
					// status contents are never written here
					if (is_first)
						nxt_svc_ff = wwd_pkg::SVC_ARMED;
					else
						nxt_svc_ff = wwd_pkg::SVC_IDLE;
				end
				wwd_pkg::ADDR_OPT1:
				begin
					if (!opt1_lock_ff)
					begin
						nxt_cfg_ff.tsel = wdata_ff[wwd_pkg::OPT1_TSEL_LSB +: 2];
						nxt_opt1_lock_ff = 1'b1;
					end
				end
				wwd_pkg::ADDR_OPT2:
				begin
					if (!opt2_lock_ff)
					begin
						nxt_cfg_ff.clk_sel = wdata_ff[wwd_pkg::OPT2_CLKSEL_BIT];
						nxt_cfg_ff.win_en = wdata_ff[wwd_pkg::OPT2_WIN_BIT];
						nxt_opt2_lock_ff = 1'b1;
					end
				end
				wwd_pkg::ADDR_COUNT:
					nxt_bresp_ff = wwd_pkg::RESP_OKAY;
				default:
					nxt_bresp_ff = wwd_pkg::RESP_SLVERR;
			endcase
		end
		// counter
		if (!enabled)
			nxt_cnt_ff = 19'h0_0000;
		else if (svc_done)
			nxt_cnt_ff = 19'h0_0000;
		else if (halt && cfg_ff.clk_sel)
			nxt_cnt_ff = cnt_ff;
		else if (halt)
			nxt_cnt_ff = 19'h0_0000;
		else if (tick)
			nxt_cnt_ff = cnt_ff + 19'h0_0001;
		// reads
		if (s_axi_rvalid & s_axi_rready)
			nxt_rvalid_ff = 1'b0;
		if (s_axi_arvalid & s_axi_arready)
		begin
			nxt_rvalid_ff = 1'b1;
			nxt_rresp_ff = wwd_pkg::RESP_OKAY;
			nxt_rdata_ff = 32'h0000_0000;
			case (s_axi_araddr)
				wwd_pkg::ADDR_RSTAT:
					nxt_rdata_ff[wwd_pkg::RSTAT_WDOG_BIT] = cause_ff;
				wwd_pkg::ADDR_OPT1:
					nxt_rdata_ff[wwd_pkg::OPT1_TSEL_LSB +: 2] = cfg_ff.tsel;
				wwd_pkg::ADDR_OPT2:
				begin
					nxt_rdata_ff[wwd_pkg::OPT2_CLKSEL_BIT] = cfg_ff.clk_sel;
					nxt_rdata_ff[wwd_pkg::OPT2_WIN_BIT] = cfg_ff.win_en;
				end
				wwd_pkg::ADDR_COUNT:
					nxt_rdata_ff[18:0] = cnt_ff;
				default:
					nxt_rresp_ff = wwd_pkg::RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cfg_ff <= '{tsel: wwd_pkg::TSEL_RST, clk_sel: wwd_pkg::CLKSEL_RST,
				win_en: wwd_pkg::WIN_RST};
			opt1_lock_ff <= 1'b0;
			opt2_lock_ff <= 1'b0;
			svc_ff <= wwd_pkg::SVC_IDLE;
			cnt_ff <= 19'h0_0000;
			lpo_ff <= 15'h0000;
			aw_ok_ff <= 1'b0;
			w_ok_ff <= 1'b0;
			awaddr_ff <= 32'h0000_0000;
			wdata_ff <= 32'h0000_0000;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= 2'h0;
		end
		else
		begin
			cfg_ff <= nxt_cfg_ff;
			opt1_lock_ff <= nxt_opt1_lock_ff;
			opt2_lock_ff <= nxt_opt2_lock_ff;
			svc_ff <= nxt_svc_ff;
			cnt_ff <= nxt_cnt_ff;
			lpo_ff <= nxt_lpo_ff;
			aw_ok_ff <= nxt_aw_ok_ff;
			w_ok_ff <= nxt_w_ok_ff;
			awaddr_ff <= nxt_awaddr_ff;
			wdata_ff <= nxt_wdata_ff;
			bvalid_ff <= nxt_bvalid_ff;
			bresp_ff <= nxt_bresp_ff;
			rvalid_ff <= nxt_rvalid_ff;
			rdata_ff <= nxt_rdata_ff;
			rresp_ff <= nxt_rresp_ff;
		end
	end

	// ==========================================================
	// reset request and cause; cause kept across a watchdog-caused system reset
	always_comb
	begin
		nxt_hold_ff = hold_ff;
		nxt_cause_ff = cause_ff;
		nxt_in_wd_rst_ff = in_wd_rst_ff;
		if (!rst_n)
		begin
			// request drops once the system reset has begun
			nxt_hold_ff = 1'b0;
			nxt_in_wd_rst_ff = hold_ff | in_wd_rst_ff;
			if (!hold_ff && !in_wd_rst_ff)
				nxt_cause_ff = 1'b0;
		end
		else
		begin
			nxt_in_wd_rst_ff = 1'b0;
			if (fire)
			begin
				nxt_hold_ff = 1'b1;
				nxt_cause_ff = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!por_n)
		begin
			hold_ff <= 1'b0;
			cause_ff <= 1'b0;
			in_wd_rst_ff <= 1'b0;
		end
		else
		begin
			hold_ff <= nxt_hold_ff;
			cause_ff <= nxt_cause_ff;
			in_wd_rst_ff <= nxt_in_wd_rst_ff;
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready = ~aw_ok_ff & ~bvalid_ff;
	assign s_axi_wready = ~w_ok_ff & ~bvalid_ff;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;
	assign sys_reset_req = hold_ff;

	// ==========================================================
	// assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n || !por_n);

	property p_reset_cfg;
		$rose(rst_n) |-> cfg_ff.tsel == 2'h3 && !cfg_ff.clk_sel && !cfg_ff.win_en;
	endproperty
	a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset config");

	property p_off_clear;
		cfg_ff.tsel == 2'h0 |=> cnt_ff == 19'h0_0000 && (!$rose(sys_reset_req) || $past(fire_bad));
	endproperty
	a_off_clear: assert property (p_off_clear) else $error("disabled timer moved");

	property p_service;
		svc_done |=> cnt_ff == 19'h0_0000 && !sys_reset_req;
	endproperty
	a_service: assert property (p_service) else $error("service did not restart");

	property p_lone_second;
		rs_wr && is_second && svc_ff == wwd_pkg::SVC_IDLE |-> !svc_done;
	endproperty
	a_lone_second: assert property (p_lone_second) else $error("lone second restarted");

	property p_bad_value;
		rs_wr && wdata_ff != 32'h0000_0055 && wdata_ff != 32'h0000_00AA |=> sys_reset_req;
	endproperty
	a_bad_value: assert property (p_bad_value) else $error("bad value no reset");

	property p_timeout;
		enabled && tick && !halt && !svc_done && cnt_ff == limit - 19'h0_0001
			|=> sys_reset_req && cause_ff;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout no reset");

	property p_bus_count;
		enabled && cfg_ff.clk_sel && !halt && !svc_done && !rs_wr
			|=> cnt_ff == $past(cnt_ff) + 19'h0_0001;
	endproperty
	a_bus_count: assert property (p_bus_count) else $error("bus count stalled");

	property p_lpo_step;
		enabled && !cfg_ff.clk_sel && !halt && !tick && !svc_done |=> $stable(cnt_ff);
	endproperty
	a_lpo_step: assert property (p_lpo_step) else $error("slow count moved early");

	property p_early;
		rs_wr && is_first && enabled && windowed && cnt_ff < win_open |=> sys_reset_req;
	endproperty
	a_early: assert property (p_early) else $error("early service no reset");

	property p_no_window;
		!cfg_ff.clk_sel |-> !fire_early;
	endproperty
	a_no_window: assert property (p_no_window) else $error("window on slow clock");

	property p_lock;
		opt1_lock_ff && opt2_lock_ff |=> $stable(cfg_ff);
	endproperty
	a_lock: assert property (p_lock) else $error("locked config changed");

	property p_halt_bus;
		enabled && cfg_ff.clk_sel && halt && !svc_done |=> $stable(cnt_ff);
	endproperty
	a_halt_bus: assert property (p_halt_bus) else $error("count moved while halted");

	property p_halt_lpo;
		enabled && !cfg_ff.clk_sel && halt |=> cnt_ff == 19'h0_0000;
	endproperty
	a_halt_lpo: assert property (p_halt_lpo) else $error("slow count not cleared");

	property p_rstat_read;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h0000_0000
			|=> s_axi_rdata == {26'h000_0000, $past(cause_ff), 5'h00};
	endproperty
	a_rstat_read: assert property (p_rstat_read) else $error("status readback wrong");

	c_service: cover property (svc_done);
	c_timeout: cover property (fire_to);
	c_early: cover property (fire_early);
	c_halt_bus: cover property (halt && cfg_ff.clk_sel && enabled);
endmodule

// ---- design/wwd_pkg.sv ----
// constants, types and register map of the windowed watchdog timer
package wwd_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [31:0] ADDR_RSTAT = 32'h0000_0000;
	localparam logic [31:0] ADDR_OPT1 = 32'h0000_0004;
	localparam logic [31:0] ADDR_OPT2 = 32'h0000_0008;
	localparam logic [31:0] ADDR_COUNT = 32'h0000_000C;
	// ==========================================================
	// field positions
	localparam int RSTAT_WDOG_BIT = 5;
	localparam int OPT1_TSEL_LSB = 0;
	localparam int OPT2_CLKSEL_BIT = 0;
	localparam int OPT2_WIN_BIT = 1;
	// ==========================================================
	// service values
	localparam logic [31:0] SVC_FIRST = 32'h0000_0055;
	localparam logic [31:0] SVC_SECOND = 32'h0000_00AA;
	// ==========================================================
	// timeout select codes and reset values
	localparam logic [1:0] TSEL_OFF = 2'h0;
	localparam logic [1:0] TSEL_SHORT = 2'h1;
	localparam logic [1:0] TSEL_MID = 2'h2;
	localparam logic [1:0] TSEL_LONG = 2'h3;
	localparam logic [1:0] TSEL_RST = TSEL_LONG;
	localparam logic CLKSEL_RST = 1'b0;
	localparam logic WIN_RST = 1'b0;
	// ==========================================================
	// counts
	localparam int CNT_W = 19;
	localparam logic [18:0] LPO_TO_SHORT = 19'h0_0020;
	localparam logic [18:0] LPO_TO_MID = 19'h0_0100;
	localparam logic [18:0] LPO_TO_LONG = 19'h0_0400;
	localparam logic [18:0] BUS_TO_SHORT = 19'h0_2000;
	localparam logic [18:0] BUS_TO_MID = 19'h1_0000;
	localparam logic [18:0] BUS_TO_LONG = 19'h4_0000;
	localparam logic [18:0] BUS_WIN_SHORT = 19'h0_1800;
	localparam logic [18:0] BUS_WIN_MID = 19'h0_C000;
	localparam logic [18:0] BUS_WIN_LONG = 19'h3_0000;
	// ==========================================================
	// low-power tick timing
	localparam int CORE_HZ = 25_000_000;
	localparam int LPO_HZ = 1_000;
	localparam int LPO_DIV = CORE_HZ / LPO_HZ;
	localparam int LPO_W = 15;
	// ==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// types
	typedef struct packed {
		logic [1:0] tsel;
		logic clk_sel;
		logic win_en;
	} wwd_cfg_t;
	typedef enum {SVC_IDLE, SVC_ARMED} wwd_svc_t;
endpackage

// ---- verif/wwd_cpu_model.sv ----
// cpu-side bus master that issues the software register cycles
`timescale 1ns/100ps
module wwd_cpu_model (
	input wire logic core_clk,
	output logic [31:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [31:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial
	begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// ==========================================================
	// bus cycles; caller enters just after a rising edge
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		// spare edge so the next cycle never re-drives in the same step
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask
	// ==========================================================
	// software habits
	task automatic svc();
		logic [1:0] r;
		wr(wwd_pkg::ADDR_RSTAT, wwd_pkg::SVC_FIRST, r);
		wr(wwd_pkg::ADDR_RSTAT, wwd_pkg::SVC_SECOND, r);
	endtask
	task automatic lock(input logic [1:0] tsel, input logic clk_sel, input logic win);
		logic [1:0] r;
		wr(wwd_pkg::ADDR_OPT1, {30'h0000_0000, tsel}, r);
		wr(wwd_pkg::ADDR_OPT2, {30'h0000_0000, win, clk_sel}, r);
	endtask
endmodule

// ---- verif/tb_wwd_top.sv ----
// self-checking bench for the windowed watchdog timer
`timescale 1ns/100ps
module tb_wwd_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic por_n = 1'b0;
	logic stop_mode = 1'b0;
	logic debug_mode = 1'b0;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, sys_reset_req;
	int errors = 0;
	int n_tests = 0;
	localparam int DIV = 10;
	// shortened counts keep the run brief; window opens after three quarters
	localparam logic [18:0] TO_S = 19'h0_0040;
	localparam logic [18:0] TO_M = 19'h0_0080;
	localparam logic [18:0] TO_L = 19'h0_0100;
	localparam logic [18:0] WIN_S = 19'h0_0030;
	localparam logic [18:0] WIN_M = 19'h0_0060;
	localparam logic [18:0] WIN_L = 19'h0_00C0;
	always #20 core_clk = ~core_clk;
	wwd_top #(.BUS_TO_SHORT(TO_S), .BUS_TO_MID(TO_M), .BUS_TO_LONG(TO_L),
		.BUS_WIN_SHORT(WIN_S), .BUS_WIN_MID(WIN_M), .BUS_WIN_LONG(WIN_L),
		.LPO_DIV(DIV)) i_wwd_top (.core_clk(core_clk), .rst_n(rst_n), .por_n(por_n),
		.stop_mode(stop_mode), .debug_mode(debug_mode), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sys_reset_req(sys_reset_req));
	wwd_cpu_model i_wwd_cpu_model (.core_clk(core_clk), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	// ==========================================================
	// helpers
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			errors++;
		end
	endtask
	task automatic tally_and_finish();
		if (errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic do_reset(input logic por);
		rst_n <= 1'b0;
		por_n <= ~por;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		por_n <= 1'b1;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		logic [1:0] r;
		i_wwd_cpu_model.rd(a, d, r);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [1:0] r;
		i_wwd_cpu_model.wr(a, d, r);
	endtask
	// reset request must rise no earlier than lo and before hi cycles
	task automatic wait_rst(input string nm, input int lo, input int hi);
		int i;
		for (i = 0; i < hi; i++)
		begin
			@(posedge core_clk);
			if (sys_reset_req === 1'b1)
				break;
		end
		chk(nm, 32'(i >= lo && i < hi), 32'h0000_0001);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_default();
		logic [31:0] v;
		do_reset(1'b1);
		wait_rst("default timeout", 1024 * DIV - 20, 1024 * DIV + 20);
		do_reset(1'b0);
		rd(wwd_pkg::ADDR_RSTAT, v);
		chk("cause after wdog", v, 32'h0000_0020);
		do_reset(1'b1);
		rd(wwd_pkg::ADDR_RSTAT, v);
		chk("cause after por", v, 32'h0000_0000);
	endtask
	task automatic t_table();
		int lim;
		for (int c = 0; c < 2; c++)
			for (int t = 1; t < 4; t++)
			begin
				do_reset(1'b1);
				i_wwd_cpu_model.lock(2'(t), 1'(c), 1'b0);
				i_wwd_cpu_model.svc();
				if (c == 1)
					lim = (t == 1) ? int'(TO_S) : (t == 2) ? int'(TO_M) : int'(TO_L);
				else
					lim = ((t == 1) ? 32 : (t == 2) ? 256 : 1024) * DIV;
				wait_rst("timeout length", lim - DIV - 6, lim + 6);
			end
	endtask
	task automatic t_service();
		logic [31:0] v;
		do_reset(1'b1);
		i_wwd_cpu_model.lock(2'h1, 1'b1, 1'b0);
		repeat (3)
		begin
			i_wwd_cpu_model.svc();
			repeat (40) @(posedge core_clk);
			chk("serviced no reset", 32'(sys_reset_req), 32'h0000_0000);
		end
		i_wwd_cpu_model.svc();
		rd(wwd_pkg::ADDR_RSTAT, v);
		chk("status after service", v, 32'h0000_0000);
		i_wwd_cpu_model.lock(2'h0, 1'b0, 1'b0);
		repeat (30) @(posedge core_clk);
		wr(wwd_pkg::ADDR_RSTAT, wwd_pkg::SVC_SECOND);
		chk("lone second no reset", 32'(sys_reset_req), 32'h0000_0000);
		wait_rst("lone second no restart", 1, 30);
	endtask
	task automatic t_disabled();
		do_reset(1'b1);
		i_wwd_cpu_model.lock(2'h0, 1'b1, 1'b0);
		repeat (400) @(posedge core_clk);
		chk("disabled no reset", 32'(sys_reset_req), 32'h0000_0000);
		wr(wwd_pkg::ADDR_RSTAT, 32'h0000_0012);
		wait_rst("bad value reset", 0, 3);
	endtask
	task automatic t_window();
		logic [31:0] v;
		logic [18:0] win;
		int n;
		for (int t = 1; t < 4; t++)
		begin
			win = (t == 1) ? WIN_S : (t == 2) ? WIN_M : WIN_L;
			do_reset(1'b1);
			i_wwd_cpu_model.lock(2'(t), 1'b1, 1'b1);
			n = 0;
			do
			begin
				rd(wwd_pkg::ADDR_COUNT, v);
				n++;
			end
			while (v < 32'(win) - 32'h0000_0002 && n < 100);
			i_wwd_cpu_model.svc();
			chk("late service ok", 32'(sys_reset_req), 32'h0000_0000);
			rd(wwd_pkg::ADDR_COUNT, v);
			chk("window restart", 32'(v < 32'h0000_0010), 32'h0000_0001);
			i_wwd_cpu_model.svc();
			wait_rst("early service reset", 0, 3);
		end
		do_reset(1'b1);
		i_wwd_cpu_model.lock(2'h1, 1'b0, 1'b1);
		i_wwd_cpu_model.svc();
		repeat (20) @(posedge core_clk);
		chk("no window slow clock", 32'(sys_reset_req), 32'h0000_0000);
	endtask
	task automatic t_modes();
		logic [31:0] a, b;
		for (int m = 0; m < 2; m++)
		begin
			do_reset(1'b1);
			i_wwd_cpu_model.lock(2'h3, 1'b1, 1'b0);
			i_wwd_cpu_model.svc();
			stop_mode <= (m == 0);
			debug_mode <= (m == 1);
			rd(wwd_pkg::ADDR_COUNT, a);
			repeat (30) @(posedge core_clk);
			rd(wwd_pkg::ADDR_COUNT, b);
			chk("bus count held", b, a);
			stop_mode <= 1'b0;
			debug_mode <= 1'b0;
			repeat (10) @(posedge core_clk);
			rd(wwd_pkg::ADDR_COUNT, b);
			chk("bus count resumes", 32'(b > a), 32'h0000_0001);
			// an accepted rewrite would switch the timer off and zero the count
			i_wwd_cpu_model.lock(2'h0, 1'b0, 1'b0);
			rd(wwd_pkg::ADDR_COUNT, a);
			chk("lock ignores rewrite", 32'(a > b), 32'h0000_0001);
			do_reset(1'b1);
			repeat (200) @(posedge core_clk);
			stop_mode <= (m == 1);
			debug_mode <= (m == 0);
			@(posedge core_clk);
			rd(wwd_pkg::ADDR_COUNT, a);
			chk("slow count cleared", a, 32'h0000_0000);
			stop_mode <= 1'b0;
			debug_mode <= 1'b0;
			repeat (50) @(posedge core_clk);
			rd(wwd_pkg::ADDR_COUNT, a);
			chk("slow count restarts", 32'(a > 0 && a < 8), 32'h0000_0001);
		end
	endtask
	task automatic t_bus();
		logic [31:0] v;
		logic [1:0] r;
		do_reset(1'b1);
		i_wwd_cpu_model.rd(32'h0000_0010, v, r);
		chk("unmapped rresp", {30'h0000_0000, r}, {30'h0000_0000, wwd_pkg::RESP_SLVERR});
		chk("unmapped rdata", v, 32'h0000_0000);
		i_wwd_cpu_model.wr(32'h0000_0010, 32'h0000_0000, r);
		chk("unmapped bresp", {30'h0000_0000, r}, {30'h0000_0000, wwd_pkg::RESP_SLVERR});
		i_wwd_cpu_model.wr(wwd_pkg::ADDR_COUNT, 32'h0000_0000, r);
		chk("count write bresp", {30'h0000_0000, r}, {30'h0000_0000, wwd_pkg::RESP_OKAY});
	endtask
	// ==========================================================
	// sequence and watchdog
	initial
	begin
		t_default();
		t_table();
		t_service();
		t_disabled();
		t_window();
		t_modes();
		t_bus();
		tally_and_finish();
	end
	initial
	begin
		repeat (60000) @(posedge core_clk);
		errors++;
		tally_and_finish();
	end
endmodule
